// ===== hdl/dpi_irq_gen.sv
`timescale 1ns/10ps
module dpi_irq_gen (
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  input  wire logic [dpi_pkg::HP_W-1:0]   hp_status,
  input  wire logic [dpi_pkg::HP_W-1:0]   hp_int_en,
  input  wire logic                       hp_master_en,
  input  wire logic                       bw_mgmt_status,
  input  wire logic                       bw_mgmt_int_en,
  input  wire logic                       autonomous_bw_status,
  input  wire logic                       autonomous_bw_int_en,
  input  wire logic                       msi_enable,
  input  wire logic                       intx_disable,
  input  wire logic [31:0]                msi_addr_low,
  input  wire logic [31:0]                msi_addr_high,
  input  wire logic [dpi_pkg::DATA_W-1:0] msi_data,
  input  wire logic                       link_dl_down,
  input  wire logic                       port_in_partition,
  input  wire logic [dpi_pkg::INTX_W-1:0] ext_intx,
  output wire logic                       core_inta_assert,
  output wire logic                       core_inta_deassert,
  output wire logic                       up_msi_valid,
  input  wire logic                       up_msi_ready,
  output wire dpi_pkg::dpi_msi_t          up_msi,
  output wire logic [dpi_pkg::INTX_W-1:0] up_intx_assert,
  output wire logic [dpi_pkg::INTX_W-1:0] up_intx_deassert,
  output wire logic [dpi_pkg::INTX_W-1:0] intx_agg_state,
  output wire logic                       irq_cond
);
  import dpi_pkg::*;

  logic [SYNC_LEN-1:0] rst_sync;
  logic                rst_n;
  dpi_gen_state_t      s_reg;
  dpi_gen_state_t      s_next;
  logic                cond_now;
  logic                rise;
  logic                fall;
  logic                legacy_ok;
  dpi_msi_t            fresh;

  // release is delayed two edges so all state leaves reset together
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync <= SYNC_RST;
    end else begin
      rst_sync <= {rst_sync[SYNC_LEN-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sync[SYNC_LEN-1];

  assign cond_now = (hp_master_en && |(hp_status & hp_int_en)) ||
                    (bw_mgmt_status && bw_mgmt_int_en) ||
                    (autonomous_bw_status && autonomous_bw_int_en);

  assign rise      = cond_now && !s_reg.cond;
  assign fall      = !cond_now && s_reg.cond;
  assign legacy_ok = !msi_enable && !intx_disable;

  assign fresh = {msi_addr_high, msi_addr_low, msi_data};

  always_comb begin
    s_next = s_reg;
    s_next.cond   = cond_now;
    s_next.as_req = rise && legacy_ok;
    s_next.de_req = fall && legacy_ok;
    case (s_reg.st)
      MSI_IDLE: begin
        if (rise && msi_enable) begin
          s_next.st  = MSI_SEND;
          s_next.msi = fresh;
        end
      end
      MSI_SEND: begin
        // a new assertion while one is still queued is kept, not dropped
        if (up_msi_ready) begin
          if (s_reg.again || (rise && msi_enable)) begin
            s_next.msi   = fresh;
            s_next.again = 1'b0;
          end else begin
            s_next.st = MSI_IDLE;
          end
        end else if (rise && msi_enable) begin
          s_next.again = 1'b1;
        end
      end
      default: begin
        s_next = GEN_RST;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= GEN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign core_inta_assert   = s_reg.as_req;
  assign core_inta_deassert = s_reg.de_req;
  assign up_msi_valid       = (s_reg.st == MSI_SEND);
  assign up_msi             = s_reg.msi;
  assign irq_cond           = s_reg.cond;

  dpi_intx_agg u_agg (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .own_set     (s_reg.as_req),
    .own_clr     (s_reg.de_req),
    .ext_intx    (ext_intx),
    .port_up     (port_in_partition && !link_dl_down),
    .up_assert   (up_intx_assert),
    .up_deassert (up_intx_deassert),
    .agg_state   (intx_agg_state)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_msi_cause;
    rise && msi_enable;
  endsequence

  sequence s_msi_idle_cause;
    s_msi_cause ##0 (s_reg.st == MSI_IDLE);
  endsequence

  chk_msi_on_rise: assert property (
    s_msi_cause |=> up_msi_valid && !core_inta_assert)
    else $error("msi not raised on condition assertion");

  chk_msi_address: assert property (
    s_msi_idle_cause |=> up_msi.addr == $past(fresh.addr))
    else $error("msi address not taken from address inputs");

  chk_msi_hold: assert property (
    up_msi_valid && !up_msi_ready |=> up_msi_valid && $stable(up_msi))
    else $error("msi dropped or changed before upstream took it");

  chk_inta_assert: assert property (
    rise && legacy_ok |=> core_inta_assert ##1 !core_inta_assert)
    else $error("assert inta request missing or longer than one cycle");

  chk_inta_blocked: assert property (
    !rise |=> !core_inta_assert)
    else $error("assert inta request without condition assertion");

  chk_inta_deassert: assert property (
    fall |=> core_inta_deassert == $past(legacy_ok))
    else $error("deassert inta request wrong on condition negation");

  chk_cond_removed: assert property (
    !hp_master_en && !bw_mgmt_int_en && !autonomous_bw_int_en
    |=> !irq_cond)
    else $error("condition stayed after all sources masked");

  chk_hp_source: assert property (
    hp_master_en && |(hp_status & hp_int_en) |=> irq_cond)
    else $error("hot-plug status did not raise condition");

  chk_bw_source: assert property (
    (bw_mgmt_status && bw_mgmt_int_en) ||
    (autonomous_bw_status && autonomous_bw_int_en) |=> irq_cond)
    else $error("bandwidth status did not raise condition");

  chk_cond_gated: assert property (
    !(|(hp_status & hp_int_en)) && !bw_mgmt_int_en &&
    !autonomous_bw_int_en |=> !irq_cond)
    else $error("condition raised by a disabled bit");

  // one pending msi at most; later rises merge into it, trading count
  // accuracy for a single flag
  sequence s_msi_taken;
    up_msi_valid && up_msi_ready;
  endsequence

  chk_msi_requeue: assert property (
    s_msi_taken ##0 (s_reg.again || (rise && msi_enable))
    |=> up_msi_valid && (up_msi.data == $past(msi_data)))
    else $error("queued msi not resent with fresh content");

  chk_msi_retire: assert property (
    s_msi_taken ##0 (!s_reg.again && !(rise && msi_enable))
    |=> !up_msi_valid)
    else $error("msi still offered after acceptance");

  chk_msi_no_cause: assert property (
    !up_msi_valid && !(rise && msi_enable) |=> !up_msi_valid)
    else $error("msi raised without condition assertion");

  chk_msi_data: assert property (
    s_msi_idle_cause |=> up_msi.data == $past(msi_data))
    else $error("msi data not taken from data input");

  chk_deassert_only_fall: assert property (
    !fall |=> !core_inta_deassert)
    else $error("deassert inta request without condition negation");

  chk_port_down: assert property (
    link_dl_down || !port_in_partition |=> intx_agg_state == INTX_NONE)
    else $error("aggregate not negated while port down");

endmodule

// ===== hdl/dpi_pkg.sv
package dpi_pkg;

  localparam int          HP_W      = 4;
  localparam int          INTX_W    = 4;
  localparam int          INTA_IDX  = 0;
  localparam int          ADDR_W    = 64;
  localparam int          DATA_W    = 16;
  localparam int          SYNC_LEN  = 2;
  localparam logic [1:0]  SYNC_RST  = 2'h0;
  localparam logic [3:0]  INTX_NONE = 4'h0;

  typedef enum logic [1:0] {
    MSI_IDLE = 2'b01,
    MSI_SEND = 2'b10
  } dpi_msi_st_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dpi_msi_t;

  typedef struct packed {
    logic        cond;
    dpi_msi_st_t st;
    logic        again;
    dpi_msi_t    msi;
    logic        as_req;
    logic        de_req;
  } dpi_gen_state_t;

  typedef struct packed {
    logic              own_a;
    logic [INTX_W-1:0] agg;
    logic [INTX_W-1:0] up_as;
    logic [INTX_W-1:0] up_de;
  } dpi_agg_state_t;

  localparam dpi_gen_state_t GEN_RST = '{
    cond: 1'b0, st: MSI_IDLE, again: 1'b0, msi: '0,
    as_req: 1'b0, de_req: 1'b0};

  localparam dpi_agg_state_t AGG_RST = '{
    own_a: 1'b0, agg: INTX_NONE, up_as: INTX_NONE, up_de: INTX_NONE};

endpackage

// ===== hdl/dpi_intx_agg.sv
`timescale 1ns/10ps
module dpi_intx_agg (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       own_set,
  input  wire logic                       own_clr,
  input  wire logic [dpi_pkg::INTX_W-1:0] ext_intx,
  input  wire logic                       port_up,
  output wire logic [dpi_pkg::INTX_W-1:0] up_assert,
  output wire logic [dpi_pkg::INTX_W-1:0] up_deassert,
  output wire logic [dpi_pkg::INTX_W-1:0] agg_state
);
  import dpi_pkg::*;

  dpi_agg_state_t    s_reg;
  dpi_agg_state_t    s_next;
  logic              own_now;
  logic [INTX_W-1:0] lvl;

  // set and clear never arrive together; port loss wins over both
  assign own_now = port_up && ((s_reg.own_a || own_set) && !own_clr);

  genvar gi;
  generate
    for (gi = 0; gi < INTX_W; gi++) begin : g_wire
      if (gi == INTA_IDX) begin : g_own
        assign lvl[gi] = port_up && (ext_intx[gi] || own_now);
      end else begin : g_ext
        assign lvl[gi] = port_up && ext_intx[gi];
      end
    end
  endgenerate

  always_comb begin
    s_next = s_reg;
    s_next.own_a = own_now;
    s_next.agg   = lvl;
    s_next.up_as = lvl & ~s_reg.agg;
    s_next.up_de = ~lvl & s_reg.agg;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= AGG_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign up_assert   = s_reg.up_as;
  assign up_deassert = s_reg.up_de;
  assign agg_state   = s_reg.agg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_up_edges: assert property (
    ##1 (up_assert == (agg_state & ~$past(agg_state))) &&
        (up_deassert == (~agg_state & $past(agg_state))))
    else $error("upstream intx message does not match aggregate edge");

  chk_down_negate: assert property (
    !port_up |=> (agg_state == INTX_NONE) && !s_reg.own_a)
    else $error("wires not negated after port down");

  chk_own_only_a: assert property (
    (ext_intx[INTX_W-1:1] == 3'h0) |=> (agg_state[INTX_W-1:1] == 3'h0))
    else $error("own interrupt reached a wire other than inta");

endmodule

// ===== test/dpi_up_port_model.sv
`timescale 1ns/10ps
module dpi_up_port_model (
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  input  wire logic              up_msi_valid,
  input  wire dpi_pkg::dpi_msi_t up_msi,
  input  wire logic [3:0]        lat,
  output logic                   up_msi_ready,
  output dpi_pkg::dpi_msi_t      last_msi,
  output logic [7:0]             n_acc
);
  import dpi_pkg::*;
  logic [3:0] cnt;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      up_msi_ready <= 1'b0;
      last_msi     <= '0;
      n_acc        <= 8'h0;
      cnt          <= 4'h0;
    end else if (up_msi_valid && up_msi_ready) begin
      last_msi     <= up_msi;
      n_acc        <= n_acc + 8'h1;
      up_msi_ready <= 1'b0;
      cnt          <= 4'h0;
    end else if (up_msi_valid) begin
      // stall for lat+1 cycles before taking it
      cnt          <= cnt + 4'h1;
      up_msi_ready <= (cnt >= lat);
    end
  end
endmodule

// ===== test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import dpi_pkg::*;
  logic              clk_sys = 1'b0;
  logic              arst_n = 1'b0;
  logic [HP_W-1:0]   hp_status = 4'h0;
  logic [HP_W-1:0]   hp_int_en = 4'h0;
  logic              hp_master_en = 1'b0;
  logic              bw_mgmt_status = 1'b0;
  logic              bw_mgmt_int_en = 1'b0;
  logic              autonomous_bw_status = 1'b0;
  logic              autonomous_bw_int_en = 1'b0;
  logic              msi_enable = 1'b0;
  logic              intx_disable = 1'b0;
  logic [31:0]       msi_addr_low = 32'hFEE0_1004;
  logic [31:0]       msi_addr_high = 32'h0000_0001;
  logic [DATA_W-1:0] msi_data = 16'hA5C3;
  logic              link_dl_down = 1'b0;
  logic              port_in_partition = 1'b1;
  logic [INTX_W-1:0] ext_intx = 4'h0;
  logic [3:0]        lat = 4'h3;
  logic              core_inta_assert;
  logic              core_inta_deassert;
  logic              up_msi_valid;
  logic              up_msi_ready;
  dpi_msi_t          up_msi;
  dpi_msi_t          last_msi;
  logic [INTX_W-1:0] up_intx_assert;
  logic [INTX_W-1:0] up_intx_deassert;
  logic [INTX_W-1:0] intx_agg_state;
  logic              irq_cond;
  logic [7:0]        n_acc;
  logic [3:0]        n_as;
  logic [3:0]        n_de;
  logic [3:0][3:0]   n_ua;
  logic [3:0][3:0]   n_ud;
  int                n_fail = 0;
  int                comparisons = 0;
  int                cyc = 0;

  dpi_irq_gen uut (.clk_sys, .arst_n, .hp_status, .hp_int_en,
    .hp_master_en, .bw_mgmt_status, .bw_mgmt_int_en,
    .autonomous_bw_status, .autonomous_bw_int_en, .msi_enable,
    .intx_disable, .msi_addr_low, .msi_addr_high, .msi_data,
    .link_dl_down, .port_in_partition, .ext_intx, .core_inta_assert,
    .core_inta_deassert, .up_msi_valid, .up_msi_ready, .up_msi,
    .up_intx_assert, .up_intx_deassert, .intx_agg_state, .irq_cond);

  dpi_up_port_model peer (.clk_sys, .arst_n, .up_msi_valid, .up_msi,
    .lat, .up_msi_ready, .last_msi, .n_acc);

  always #25 clk_sys = ~clk_sys;

  // pulse counters on the falling edge: a pulse counts once, and checks
  // and clears at the rising edge never race them
  always @(negedge clk_sys) begin
    cyc++;
    n_as += core_inta_assert;
    n_de += core_inta_deassert;
    for (int i = 0; i < 4; i++) begin
      n_ua[i] += up_intx_assert[i];
      n_ud[i] += up_intx_deassert[i];
    end
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic clr();
    n_as = 4'h0;
    n_de = 4'h0;
    n_ua = 16'h0;
    n_ud = 16'h0;
    @(posedge clk_sys);
  endtask

  task automatic chk(input logic [79:0] got, input logic [79:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, what, got,
               exp);
    end
  endtask

  task automatic endt(input string s);
    $display("test %s finished, mismatches so far %0d", s, n_fail);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    step(4);
    arst_n <= 1'b1;
    step(6);
    hp_master_en <= 1'b1;
    hp_int_en <= 4'h2;
    clr();
    hp_status <= 4'h2;
    step(4);
    chk(irq_cond, 1'b1, "hot-plug cond");
    chk({n_as, n_de}, 8'h10, "assert inta");
    chk(intx_agg_state, 4'h1, "aggregate");
    chk(n_ua, 16'h0001, "only inta up");
    clr();
    hp_status <= 4'h0;
    step(4);
    chk({n_as, n_de}, 8'h01, "deassert inta");
    chk(n_ud, 16'h0001, "up deassert");
    endt("intx");
    clr();
    intx_disable <= 1'b1;
    hp_status <= 4'h2;
    step(4);
    chk({irq_cond, n_as}, 5'h10, "intx disabled");
    clr();
    hp_status <= 4'h0;
    step(4);
    chk(n_de, 4'h0, "no deassert");
    endt("intx disabled");
    clr();
    msi_enable <= 1'b1;
    bw_mgmt_int_en <= 1'b1;
    bw_mgmt_status <= 1'b1;
    step(10);
    chk(n_acc, 8'h1, "msi sent");
    chk(last_msi, {msi_addr_high, msi_addr_low, msi_data}, "msi");
    chk(n_as, 4'h0, "no inta");
    clr();
    bw_mgmt_status <= 1'b0;
    lat <= 4'h0;
    msi_data <= 16'h5A3C;
    step(4);
    chk({n_de, n_acc}, 12'h001, "msi fall");
    hp_status <= 4'h2;
    step(6);
    chk(n_acc, 8'h2, "prompt msi");
    chk(last_msi, {msi_addr_high, msi_addr_low, msi_data}, "msi2");
    hp_status <= 4'h0;
    step(4);
    lat <= 4'h3;
    hp_status <= 4'h2;
    step(2);
    hp_status <= 4'h0;
    step(1);
    hp_status <= 4'h2;
    step(1);
    msi_data <= 16'h3C5A;
    step(10);
    chk(n_acc, 8'h4, "queued msi");
    chk(last_msi, {msi_addr_high, msi_addr_low, msi_data}, "msi3");
    hp_status <= 4'h0;
    step(4);
    endt("msi");
    clr();
    msi_enable <= 1'b0;
    intx_disable <= 1'b0;
    autonomous_bw_status <= 1'b1;
    step(4);
    chk({irq_cond, n_as}, 5'h00, "notify off");
    clr();
    autonomous_bw_int_en <= 1'b1;
    step(4);
    chk({irq_cond, n_as}, 5'h11, "notify on");
    clr();
    autonomous_bw_int_en <= 1'b0;
    step(4);
    chk({irq_cond, n_de}, 5'h01, "masked");
    endt("notify");
    clr();
    ext_intx <= 4'h4;
    hp_status <= 4'h2;
    step(4);
    chk(intx_agg_state, 4'h5, "agg up");
    chk(n_ua, 16'h0101, "up asserts");
    clr();
    link_dl_down <= 1'b1;
    step(4);
    chk(intx_agg_state, 4'h0, "agg down");
    chk(n_ud, 16'h0101, "up deasserts");
    endt("aggregate");
    report_and_stop();
  end
endmodule
